// *** verilog/pixel_link_pkg.sv ***
// shared constants of the serial pixel link
package pixel_link_pkg;
    localparam int COLOUR_BITS       = 6;
    localparam int LANE_BITS         = 7;
    localparam int LANE_COUNT        = 3;
    localparam int SYS_CLK_MHZ       = 50;
    // nominal panel rate, for reference only; this link runs slower
    localparam int LINK_TYPICAL_KHZ  = 68900;
    // each serial bit holds for this many system clocks
    localparam int BIT_CYCLES        = 4;
    localparam int PIXEL_CYCLES      = LANE_BITS * BIT_CYCLES;
    localparam int CLOCK_HIGH_SLOT   = 3;

    typedef logic [4:0] count_t;
    typedef logic [LANE_BITS-1:0] lane_word_t;

    localparam count_t     PIXEL_LAST       = count_t'(PIXEL_CYCLES - 1);
    localparam count_t     CLOCK_HIGH_START = count_t'(CLOCK_HIGH_SLOT * BIT_CYCLES);
    localparam count_t     COUNT_MAX        = 5'h1F;
    localparam count_t     PERIOD_MIN       = count_t'(PIXEL_CYCLES - 2);
    localparam logic [1:0] BIT_LAST_PHASE   = 2'h3;
    localparam logic [1:0] SAMPLE_PHASE     = 2'h1;
    localparam lane_word_t WORD_RESET       = 7'h00;

    // positions inside the lane words, slot 0 is bit 6 and leaves first
    localparam int L0_GREEN_ZERO = 6;
    localparam int L1_BLUE_LOW   = 5;
    localparam int L2_QUALIFIER  = 6;
    localparam int L2_FRAME_SYNC = 5;
    localparam int L2_LINE_SYNC  = 4;
endpackage

// *** verilog/link_if.sv ***
// differential lanes and forwarded clock between host and panel
interface link_if;
    logic data_lane_zero_p;
    logic data_lane_zero_n;
    logic data_lane_one_p;
    logic data_lane_one_n;
    logic data_lane_two_p;
    logic data_lane_two_n;
    logic link_pixel_clock_p;
    logic link_pixel_clock_n;

    modport host_end (
        output data_lane_zero_p, data_lane_zero_n,
        output data_lane_one_p,  data_lane_one_n,
        output data_lane_two_p,  data_lane_two_n,
        output link_pixel_clock_p, link_pixel_clock_n
    );
    modport panel_end (
        input  data_lane_zero_p, data_lane_zero_n,
        input  data_lane_one_p,  data_lane_one_n,
        input  data_lane_two_p,  data_lane_two_n,
        input  link_pixel_clock_p, link_pixel_clock_n
    );
endinterface

// *** verilog/lane_receiver.sv ***
// one differential lane: synchroniser, receiver and shift register
module lane_receiver (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    input  wire logic                     lane_p,
    input  wire logic                     lane_n,
    input  wire logic                     sample_strobe,
    output pixel_link_pkg::lane_word_t    word
);
    logic                       p_s1_q;
    logic                       p_s2_q;
    logic                       n_s1_q;
    logic                       n_s2_q;
    logic                       level;
    pixel_link_pkg::lane_word_t word_q;

    ////////////////////////////////////////////////////////////////////////
    // same two-flop delay as the clock lane keeps bits aligned to it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            p_s1_q <= 1'b0;
            p_s2_q <= 1'b0;
            n_s1_q <= 1'b0;
            n_s2_q <= 1'b0;
        end else begin
            p_s1_q <= lane_p;
            p_s2_q <= p_s1_q;
            n_s1_q <= lane_n;
            n_s2_q <= n_s1_q;
        end
    end

    // both legs low (undriven) reads as zero
    assign level = p_s2_q & ~n_s2_q; // R9

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            word_q <= pixel_link_pkg::WORD_RESET;
        end else if (sample_strobe) begin
            word_q <= {word_q[pixel_link_pkg::LANE_BITS-2:0], level}; // R12
        end
    end

    assign word = word_q;
endmodule

// *** verilog/panel_link_receiver.sv ***
// panel end: recovers pixels from three lanes and the forwarded clock
// How it works
// R1: three colours, six bits, bit 5 MSB
// R2: forwarded clock strobes pixels and qualifier
// R3: host keeps data valid while qualifier high
// R4: qualifier low means pixel not displayed
// R5: host changes syncs only with link clock
// R6: lane zero: red bits plus green zero
// R7: lane one: green one-five, blue zero-one
// R8: lane two: blue two-five, syncs, qualifier
// R9: three differential data lanes plus clock lane
// R10: host drives link low when panel off
// R11: host sends 1280 by 800 at 60 Hz; this link moves one pixel per 28 system clocks, far below that rate
// R12: seven bits per lane per clock period
module panel_link_receiver (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    link_if.panel_end        link,
    output logic [5:0]       red_component,
    output logic [5:0]       green_component,
    output logic [5:0]       blue_component,
    output logic             active_video_qualifier,
    output logic             line_sync,
    output logic             frame_sync,
    output logic             pixel_valid
);
    // link lock state
    typedef enum logic [0:0] {
        LINK_IDLE   = 1'b0,
        LINK_LOCKED = 1'b1
    } lock_e;

    logic                       clk_p_s1_q;
    logic                       clk_p_s2_q;
    logic                       clk_n_s1_q;
    logic                       clk_n_s2_q;
    logic                       clk_prev_q;
    logic                       clk_level;
    logic                       clock_fall;
    logic                       clk_dead;
    logic                       clk_stopped;
    logic                       locked;
    lock_e                      lock_q;
    lock_e                      lock_d;
    pixel_link_pkg::count_t     cnt_q;
    logic                       sample_strobe;
    logic                       word_full;
    logic                       take;
    logic [2:0]                 lane_p;
    logic [2:0]                 lane_n;
    pixel_link_pkg::lane_word_t words [pixel_link_pkg::LANE_COUNT];
    logic [5:0]                 red_q;
    logic [5:0]                 green_q;
    logic [5:0]                 blue_q;
    logic                       qual_q;
    logic                       line_q;
    logic                       frame_q;
    logic                       valid_q;
    logic [5:0]                 red_w;
    logic [5:0]                 green_w;
    logic [5:0]                 blue_w;
    logic                       qual_w;
    logic                       line_w;
    logic                       frame_w;

    ////////////////////////////////////////////////////////////////////////
    // forwarded clock: synchronised, then its falling edge found
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_p_s1_q <= 1'b0;
            clk_p_s2_q <= 1'b0;
            clk_n_s1_q <= 1'b0;
            clk_n_s2_q <= 1'b0;
            clk_prev_q <= 1'b0;
        end else begin
            clk_p_s1_q <= link.link_pixel_clock_p;
            clk_p_s2_q <= clk_p_s1_q;
            clk_n_s1_q <= link.link_pixel_clock_n;
            clk_n_s2_q <= clk_n_s1_q;
            clk_prev_q <= clk_level;
        end
    end

    assign clk_level  = clk_p_s2_q & ~clk_n_s2_q; // R9
    assign clock_fall = clk_prev_q & ~clk_level; // R2

    ////////////////////////////////////////////////////////////////////////
    // bit phase counter restarts at every falling edge
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 5'h00;
        end else if (clock_fall) begin
            cnt_q <= 5'h00;
        end else if (cnt_q != pixel_link_pkg::COUNT_MAX) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // after reset, power loss or a stall the first fall only aligns
    assign clk_dead    = ~clk_p_s2_q & ~clk_n_s2_q;
    assign clk_stopped = (cnt_q == pixel_link_pkg::COUNT_MAX);
    assign locked      = (lock_q == LINK_LOCKED);

    always_comb begin
        lock_d = lock_q;
        case (lock_q)
            LINK_IDLE: begin
                if (clock_fall && !clk_dead) begin
                    lock_d = LINK_LOCKED;
                end
            end
            LINK_LOCKED: begin
                if (clk_dead || clk_stopped) begin
                    lock_d = LINK_IDLE;
                end
            end
            default: begin
                lock_d = LINK_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_q <= LINK_IDLE;
        end else begin
            lock_q <= lock_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mid-bit sampling; a stopped clock yields no more than seven strobes
    assign sample_strobe = locked && (cnt_q[1:0] == pixel_link_pkg::SAMPLE_PHASE)
                           && (cnt_q < pixel_link_pkg::PIXEL_LAST); // R12
    // short period means a glitch; a fall into an undriven pair is not a word
    assign word_full = locked && !clk_dead && !clk_stopped
                       && (cnt_q >= pixel_link_pkg::PERIOD_MIN);
    assign take      = clock_fall && word_full; // R4

    // legs in lane order, lane zero lowest
    assign lane_p = {link.data_lane_two_p, link.data_lane_one_p, link.data_lane_zero_p};
    assign lane_n = {link.data_lane_two_n, link.data_lane_one_n, link.data_lane_zero_n};

    generate
        for (genvar i = 0; i < pixel_link_pkg::LANE_COUNT; i++) begin : g_lane
            lane_receiver u_lane (
                .sys_clk       (sys_clk),
                .rst_n         (rst_n),
                .lane_p        (lane_p[i]),
                .lane_n        (lane_n[i]),
                .sample_strobe (sample_strobe),
                .word          (words[i])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // unpack lanes into colours
    assign red_w   = words[0][5:0]; // R6
    assign green_w = {words[1][4:0], words[0][pixel_link_pkg::L0_GREEN_ZERO]}; // R7
    assign blue_w  = {words[2][3:0], words[1][pixel_link_pkg::L1_BLUE_LOW +: 2]}; // R8
    // lane two also carries the syncs and the qualifier
    assign qual_w  = words[2][pixel_link_pkg::L2_QUALIFIER]; // R8
    assign line_w  = words[2][pixel_link_pkg::L2_LINE_SYNC];
    assign frame_w = words[2][pixel_link_pkg::L2_FRAME_SYNC];

    // colours hold the last captured pixel, displayed or not
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            red_q   <= 6'h00;
            green_q <= 6'h00;
            blue_q  <= 6'h00;
        end else if (take) begin
            red_q   <= red_w; // R1
            green_q <= green_w;
            blue_q  <= blue_w;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            qual_q  <= 1'b0;
            line_q  <= 1'b0;
            frame_q <= 1'b0;
        end else if (take) begin
            qual_q  <= qual_w; // R4
            line_q  <= line_w;
            frame_q <= frame_w;
        end
    end

    // one pulse per displayable pixel
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_q <= 1'b0;
        end else begin
            valid_q <= take && qual_w; // R4
        end
    end

    assign red_component          = red_q;
    assign green_component        = green_q;
    assign blue_component         = blue_q;
    assign active_video_qualifier = qual_q;
    assign line_sync              = line_q;
    assign frame_sync             = frame_q;
    assign pixel_valid            = valid_q;
endmodule

// *** verilog/host_link_transmitter.sv ***
// host end: serialises one pixel per forwarded clock period
module host_link_transmitter (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        panel_power_on,
    input  wire logic [5:0]  red_component,
    input  wire logic [5:0]  green_component,
    input  wire logic [5:0]  blue_component,
    input  wire logic        active_video_qualifier,
    input  wire logic        line_sync,
    input  wire logic        frame_sync,
    output logic             pixel_take,
    link_if.host_end         link
);
    pixel_link_pkg::count_t     cnt_q;
    pixel_link_pkg::lane_word_t w0_q;
    pixel_link_pkg::lane_word_t w1_q;
    pixel_link_pkg::lane_word_t w2_q;
    logic [2:0]                 lane_q;
    logic                       clk_q;
    logic                       on_q;
    logic                       take_q;
    logic                       load;
    logic                       shift;
    logic                       clock_d;

    assign load    = (cnt_q == pixel_link_pkg::PIXEL_LAST);
    assign shift   = (cnt_q[1:0] == pixel_link_pkg::BIT_LAST_PHASE);
    // low for three slots from the period start, high for four
    assign clock_d = (cnt_q >= pixel_link_pkg::CLOCK_HIGH_START); // R2

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= 5'h00;
            w0_q   <= pixel_link_pkg::WORD_RESET;
            w1_q   <= pixel_link_pkg::WORD_RESET;
            w2_q   <= pixel_link_pkg::WORD_RESET;
            take_q <= 1'b0;
        end else if (load) begin
            cnt_q  <= 5'h00;
            // syncs and pixel change only at a period boundary
            w0_q   <= {green_component[0], red_component}; // R6 R5
            w1_q   <= {blue_component[1:0], green_component[5:1]}; // R7
            w2_q   <= {active_video_qualifier, frame_sync, line_sync,
                       blue_component[5:2]}; // R8
            take_q <= panel_power_on; // R3
        end else begin
            cnt_q  <= cnt_q + 5'h01;
            take_q <= 1'b0;
            if (shift) begin
                w0_q <= {w0_q[5:0], 1'b0}; // R12
                w1_q <= {w1_q[5:0], 1'b0};
                w2_q <= {w2_q[5:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock and data registered together so the skew between them is zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lane_q <= 3'h0;
            clk_q  <= 1'b0;
            on_q   <= 1'b0;
        end else begin
            lane_q <= {w2_q[6], w1_q[6], w0_q[6]}; // R9
            clk_q  <= clock_d;
            on_q   <= panel_power_on;
        end
    end

    // both legs low while the panel supply is off
    assign link.data_lane_zero_p   = on_q & lane_q[0]; // R10
    assign link.data_lane_zero_n   = on_q & ~lane_q[0];
    assign link.data_lane_one_p    = on_q & lane_q[1];
    assign link.data_lane_one_n    = on_q & ~lane_q[1];
    assign link.data_lane_two_p    = on_q & lane_q[2];
    assign link.data_lane_two_n    = on_q & ~lane_q[2];
    assign link.link_pixel_clock_p = on_q & clk_q; // R10
    assign link.link_pixel_clock_n = on_q & ~clk_q;
    assign pixel_take              = take_q;
endmodule

// *** tb/link_checker.sv ***
// wire checker: forwarded clock shape, bit slots and differential legs
module link_checker (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic data_lane_zero_p,
    input wire logic data_lane_zero_n,
    input wire logic data_lane_one_p,
    input wire logic data_lane_one_n,
    input wire logic data_lane_two_p,
    input wire logic data_lane_two_n,
    input wire logic link_pixel_clock_p,
    input wire logic link_pixel_clock_n
);
    logic [4:0] since_fall_q;
    logic       framed_q;
    wire  logic link_off = !link_pixel_clock_p && !link_pixel_clock_n;
    wire  logic [2:0] lanes_p = {data_lane_two_p, data_lane_one_p, data_lane_zero_p};
    wire  logic [2:0] lanes_n = {data_lane_two_n, data_lane_one_n, data_lane_zero_n};
    ////////////////////////////////////////////////////////////////////////////
    // saturating count from each clock fall; framing is lost while unpowered
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            since_fall_q <= 5'h00;
            framed_q     <= 1'b0;
        end else begin
            if ($fell(link_pixel_clock_p))
                since_fall_q <= 5'h01;
            else if (since_fall_q != 5'h1F)
                since_fall_q <= since_fall_q + 5'h01;
            framed_q <= !link_off && (framed_q || $fell(link_pixel_clock_p));
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    clk_low_span_a: assert property (framed_q && $rose(link_pixel_clock_p) |->
        since_fall_q == 5'h0C) else $error("clock low phase not three bits");
    clk_period_a: assert property (framed_q && !link_off && $fell(link_pixel_clock_p) |->
        since_fall_q == 5'h1C) else $error("clock period not seven bits");
    bit_slot_a: assert property (framed_q && !link_off && $changed(lanes_p) |->
        since_fall_q[1:0] == 2'h0) else $error("lane bit changed off a slot edge");
    bit_hold_a: assert property (framed_q && !link_off && $changed(lanes_p) |=>
        ($stable(lanes_p) || link_off) [*3]) else $error("lane bit held too short");
    fall_low_a: assert property (!link_off && $fell(link_pixel_clock_p) |=>
        !link_pixel_clock_p [*8]) else $error("clock low phase too short");
    high_hold_a: assert property (framed_q && $rose(link_pixel_clock_p) |=>
        (link_pixel_clock_p || link_off) [*3]) else $error("clock high phase too short");
    diff_pair_a: assert property (!link_off |-> lanes_n == ~lanes_p &&
        link_pixel_clock_n == !link_pixel_clock_p) else $error("legs not complementary");
    off_legs_a: assert property (link_off |->
        lanes_p == 3'h0 && lanes_n == 3'h0) else $error("lane driven while clock off");
endmodule

// *** tb/testbench.sv ***
// bench: host and panel ends joined over the link, pixels checked end to end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        power_on = 1'b0;
    logic [20:0] pix_in = 21'h000000;
    logic        take;
    logic [5:0]  p_red, p_green, p_blue;
    logic        p_qual, p_line, p_frame, p_valid;
    int          err_total = 0;
    int          tests_run = 0;
    logic [20:0] word_q[$];
    logic [20:0] disp_q[$];
    // packing {qualifier, line, frame, red, green, blue}; extremes and walking bits
    logic [20:0] pix [6] = '{21'h13F03F, 21'h180FC0, 21'h06A56A, 21'h141801,
                             21'h1E0060, 21'h115A95};
    logic        clk_prev = 1'b0;
    int          slot_cnt = 0;
    logic        pend = 1'b0;
    logic [6:0]  l0, l1, l2;
    logic [20:0] w;
    link_if link_bus ();
    wire  logic [7:0] legs = {link_bus.data_lane_zero_p, link_bus.data_lane_zero_n,
        link_bus.data_lane_one_p, link_bus.data_lane_one_n, link_bus.data_lane_two_p,
        link_bus.data_lane_two_n, link_bus.link_pixel_clock_p, link_bus.link_pixel_clock_n};
    always #10 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////
    host_link_transmitter u_host_link_transmitter (
        .sys_clk(sys_clk), .rst_n(rst_n), .panel_power_on(power_on),
        .red_component(pix_in[17:12]), .green_component(pix_in[11:6]),
        .blue_component(pix_in[5:0]), .active_video_qualifier(pix_in[20]),
        .line_sync(pix_in[19]), .frame_sync(pix_in[18]), .pixel_take(take),
        .link(link_bus.host_end));
    panel_link_receiver u_panel_link_receiver (
        .sys_clk(sys_clk), .rst_n(rst_n), .link(link_bus.panel_end),
        .red_component(p_red), .green_component(p_green), .blue_component(p_blue),
        .active_video_qualifier(p_qual), .line_sync(p_line), .frame_sync(p_frame),
        .pixel_valid(p_valid));
    link_checker u_link_checker (
        .sys_clk(sys_clk), .rst_n(rst_n),
        .data_lane_zero_p(link_bus.data_lane_zero_p),
        .data_lane_zero_n(link_bus.data_lane_zero_n),
        .data_lane_one_p(link_bus.data_lane_one_p),
        .data_lane_one_n(link_bus.data_lane_one_n),
        .data_lane_two_p(link_bus.data_lane_two_p),
        .data_lane_two_n(link_bus.data_lane_two_n),
        .link_pixel_clock_p(link_bus.link_pixel_clock_p),
        .link_pixel_clock_n(link_bus.link_pixel_clock_n));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [20:0] seen, input logic [20:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic give_up;
        err_total++;
        tally_and_finish();
    endtask
    // hold the pixel until the host takes it, then expect it on wire, and on the panel only if its qualifier is high
    task automatic send(input logic [20:0] p);
        int n;
        pix_in = p;
        for (n = 0; n < 60; n++) begin
            @(negedge sys_clk);
            if (take === 1'b1)
                break;
        end
        if (n == 60)
            give_up();
        word_q.push_back(p);
        if (p[20])
            disp_q.push_back(p);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // wire monitor: words framed by clock falls, sampled mid bit, slot 0 first
    always @(negedge sys_clk) begin
        if (clk_prev && !link_bus.link_pixel_clock_p) begin
            slot_cnt = 0;
            pend = word_q.size() > 0;
        end else
            slot_cnt++;
        clk_prev = link_bus.link_pixel_clock_p;
        if (slot_cnt % 4 == 1 && slot_cnt < 26) begin
            l0 = {l0[5:0], link_bus.data_lane_zero_p};
            l1 = {l1[5:0], link_bus.data_lane_one_p};
            l2 = {l2[5:0], link_bus.data_lane_two_p};
        end
        if (slot_cnt == 25 && pend) begin
            w = word_q.pop_front();
            check({14'h0000, l0}, {14'h0000, w[6], w[17:12]});
            check({14'h0000, l1}, {14'h0000, w[1:0], w[11:7]});
            check({14'h0000, l2}, {14'h0000, w[20], w[18], w[19], w[5:2]});
        end
    end
    // a displayed pixel with nothing expected means a blank one got through
    always @(negedge sys_clk) if (p_valid === 1'b1) begin
        if (disp_q.size() == 0)
            check(21'h000001, 21'h000000);
        else
            check({p_qual, p_line, p_frame, p_red, p_green, p_blue}, disp_q.pop_front());
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        int i, k, n;
        repeat (20) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        check({4'h0, legs, take, p_valid, p_qual, p_red}, 21'h000000);
        for (k = 0; k < 2; k++) begin
            power_on = 1'b1;
            repeat (60) @(negedge sys_clk);
            send(21'h0FFFFF);
            send(21'h0FFFFF);
            for (i = 0; i < 6; i++)
                send(pix[i]);
            send(21'h0FFFFF);
            for (n = 0; n < 300 && word_q.size() + disp_q.size() > 0; n++)
                @(negedge sys_clk);
            if (n == 300)
                give_up();
            power_on = 1'b0;
            repeat (3) @(negedge sys_clk);
            check({13'h0000, legs}, 21'h000000);
        end
        tally_and_finish();
    end
endmodule
